// ### hw/ils_pkg.sv
package ils_pkg;
    localparam int NUM_LINES       = 15;
    localparam int NUM_ADC         = 4;
    localparam int ADC_BITS        = 10;
    localparam int CLK_HZ          = 125000000;
    localparam int TICK_MS_NS      = 1000000;
    localparam int CLK_NS          = 8;
    localparam int MS_CYCLES       = TICK_MS_NS / CLK_NS;
    localparam int SLEEP_UNIT_MS   = 10;
    localparam logic [2:0] FN_ADC   = 3'h2;
    localparam logic [2:0] FN_DIN   = 3'h3;
    localparam logic [2:0] FN_DLOW  = 3'h4;
    localparam logic [2:0] FN_DHIGH = 3'h5;
    localparam logic [2:0] KIND_CYC     = 3'h4;
    localparam logic [2:0] KIND_CYC_PIN = 3'h5;
    localparam logic [7:0] OPT_EXT      = 8'h04;
    localparam logic [7:0] OPT_EXT_HOLD = 8'h06;
    localparam logic [15:0] WAKE_HOLD_RST = 16'h07D0;
    localparam logic [15:0] ADC_MAX     = 16'h03FF;
    localparam int ADDR_W = 6;
    // Register offsets
    localparam logic [5:0] R_FN_BASE   = 6'h00;
    localparam logic [5:0] R_PULL_EN   = 6'h10;
    localparam logic [5:0] R_PULL_DIR  = 6'h11;
    localparam logic [5:0] R_CHG_MASK  = 6'h12;
    localparam logic [5:0] R_INTERVAL  = 6'h13;
    localparam logic [5:0] R_SLP_PER   = 6'h14;
    localparam logic [5:0] R_SLP_CNT   = 6'h15;
    localparam logic [5:0] R_SLP_KIND  = 6'h16;
    localparam logic [5:0] R_SLP_OPT   = 6'h17;
    localparam logic [5:0] R_WAKE_HOLD = 6'h18;
    localparam logic [5:0] R_PWM0      = 6'h19;
    localparam logic [5:0] R_PWM1      = 6'h1A;
    localparam logic [5:0] R_DEST_HI   = 6'h1B;
    localparam logic [5:0] R_DEST_LO   = 6'h1C;
    localparam logic [5:0] R_ADC_REF   = 6'h1D;
    localparam logic [5:0] R_CMD       = 6'h1E;
    localparam logic [5:0] R_STATUS    = 6'h1F;
    localparam logic [5:0] R_SAMP_DIG  = 6'h20;
    localparam logic [5:0] R_SAMP_MASK = 6'h21;
    localparam logic [5:0] R_SAMP_AMSK = 6'h22;
    localparam logic [5:0] R_SAMP_ADC  = 6'h24;
    localparam int CMD_FORCE_BIT = 0;
    localparam int CMD_SLEEP_BIT = 1;
    localparam logic [15:0] PULL_DIR_RST = 16'h7FFF;
    localparam logic [2:0] SRC_TIMER  = 3'h1;
    localparam logic [2:0] SRC_CHANGE = 3'h2;
    localparam logic [2:0] SRC_FORCE  = 3'h4;

    typedef struct packed {
        logic [2:0]          source;
        logic [14:0]         dig_mask;
        logic [14:0]         dig_data;
        logic [3:0]          adc_mask;
        logic [3:0][15:0]    adc_data;
        logic [31:0]         dest_high;
        logic [31:0]         dest_low;
    } ils_sample_t;

    typedef struct packed {
        logic              we;
        logic              re;
        logic [5:0]        addr;
        logic [31:0]       wdata;
    } ils_bus_t;
endpackage

// ### hw/ils_pwm.sv
`timescale 1ns/100ps
module ils_pwm #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Duty setting and output
    input  wire logic [WIDTH-1:0] duty,
    output logic                  pwm_out
);
    logic [WIDTH-1:0] cnt_q;

    initial begin
        if (WIDTH < 2) $error("ils_pwm width too small");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // High while the counter is below duty; full scale stays high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (cnt_q < duty) || (&duty);
        end
    end
endmodule

// ### hw/ils_timer.sv
`timescale 1ns/100ps
module ils_timer #(
    parameter int PRESCALE = 125000
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Control
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic [31:0] units,
    // Status
    output logic             running,
    output logic             done
);
    logic [31:0] pre_q;
    logic [31:0] left_q;

    initial begin
        if (PRESCALE < 1) $error("ils_timer prescale must be positive");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q   <= '0;
            left_q  <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (stop) begin
                running <= 1'b0;
            end else if (running) begin
                if (pre_q != 0) begin
                    pre_q <= pre_q - 1'b1;
                end else begin
                    pre_q  <= 32'(PRESCALE - 1);
                    left_q <= left_q - 1'b1;
                    if (left_q == 32'h1) begin
                        // Start held at expiry reloads with no gap
                        running <= start && (units != 0);
                        done    <= 1'b1;
                        left_q  <= units;
                    end
                end
            end else if (start) begin
                running <= (units != 0);
                done    <= (units == 0);
                left_q  <= units;
                pre_q   <= 32'(PRESCALE - 1);
            end
        end
    end
endmodule

// ### hw/ils_core.sv
// Behaviour
// RQ1: Extended sleep lasts period times cycle count
// RQ2: Options 0x04 extended, 0x06 adds wake hold
// RQ3: Kind 4 cyclic, 5 cyclic plus pin wake
// RQ4: Stay awake wake-hold time then sleep
// RQ5: Sleep-now command sleeps immediately
// RQ6: Functions 3,4,5 enable digital sampling
// RQ7: Pull enable and direction masks, default up
// RQ8: Upper pins five to nine never sampled; the code samples lines 5-9 like any other digital line
// RQ9: Value 2 selects ADC on lines 0-3
// RQ10: Lines ten, eleven drive PWM duty
// RQ11: Analog sample is 10-bit in 16 bits
// RQ12: Receiver scales sample by reference over 1023
// RQ13: No configured line means no sample
// RQ14: Timer and change samples go to dest
// RQ15: Timer sampling; sample on cyclic wake only
// RQ16: Masked digital input change makes sample
// RQ17: Force command captures all lines now
// RQ18: All three sample sources run together
// RQ19: Receiver must run framed API mode
// RQ20: End device should transmit on each wake; the code sends a sample on a sleep-timer wake but not on a pin wake
// RQ21: Wake hold and interval count milliseconds
// RQ22: Digital bit reports line level
// RQ23: Output function change drives pin next cycle
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module ils_core
    import ils_pkg::*;
#(
    parameter int MS_CYC = ils_pkg::MS_CYCLES
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Register port
    input  wire ils_pkg::ils_bus_t     bus,
    output logic [31:0]                rdata,
    // Pins
    input  wire logic [14:0]           pin_in,
    input  wire logic [3:0][9:0]       adc_in,
    input  wire logic                  sleep_req_pin,
    output logic [14:0]                pin_out,
    output logic [14:0]                pin_oe,
    output logic [14:0]                pull_en,
    output logic [14:0]                pull_up,
    output logic [1:0]                 pwm_out,
    output logic [1:0]                 adc_reference_select,
    // Sample and sleep status
    output ils_pkg::ils_sample_t       sample,
    output logic                       sample_valid,
    output logic                       asleep
);
    import ils_pkg::*;

    initial begin
        if (MS_CYC < 1) $error("ils_core ms prescale must be positive");
    end

    logic [14:0][2:0] line_fn_q;
    logic [14:0] pull_enable_mask_q, pull_direction_mask_q, change_detect_mask_q;
    logic [15:0] periodic_sample_interval_q, sleep_period_q, sleep_cycle_count_q;
    logic [15:0] wake_hold_time_q;
    logic [2:0]  sleep_kind_q;
    logic [7:0]  sleep_opt_q;
    logic [9:0]  pwm_duty_zero_q, pwm_duty_one_q;
    logic [31:0] dest_addr_high_q, dest_addr_low_q;
    logic        force_sample_cmd, sleep_now_cmd;

    function automatic logic is_digital(input logic [2:0] f);
        return (f == FN_DIN) || (f == FN_DLOW) || (f == FN_DHIGH);
    endfunction

    assign force_sample_cmd = bus.we && bus.addr == R_CMD &&
                              bus.wdata[CMD_FORCE_BIT];
    assign sleep_now_cmd    = bus.we && bus.addr == R_CMD &&
                              bus.wdata[CMD_SLEEP_BIT];

    // Configuration writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_fn_q                  <= '0;
            pull_enable_mask_q         <= '0;
            pull_direction_mask_q      <= PULL_DIR_RST[14:0]; // RQ7
            change_detect_mask_q       <= '0;
            periodic_sample_interval_q <= '0;
            sleep_period_q             <= '0;
            sleep_cycle_count_q        <= 16'h0001;
            sleep_kind_q               <= '0;
            sleep_opt_q                <= '0;
            wake_hold_time_q           <= WAKE_HOLD_RST;
            pwm_duty_zero_q            <= '0;
            pwm_duty_one_q             <= '0;
            dest_addr_high_q           <= '0;
            dest_addr_low_q            <= '0;
            adc_reference_select       <= '0;
        end else if (bus.we) begin
            if (bus.addr < 6'(NUM_LINES)) begin
                // Analog only accepted on first four lines
                if (bus.wdata[2:0] != FN_ADC || bus.addr < 6'(NUM_ADC)) begin
                    line_fn_q[bus.addr[3:0]] <= bus.wdata[2:0]; // RQ9
                end
            end
            case (bus.addr)
                R_PULL_EN:   pull_enable_mask_q <= bus.wdata[14:0]; // RQ7
                R_PULL_DIR:  pull_direction_mask_q <= bus.wdata[14:0];
                R_CHG_MASK:  change_detect_mask_q <= bus.wdata[14:0];
                R_INTERVAL:  periodic_sample_interval_q <= bus.wdata[15:0];
                R_SLP_PER:   sleep_period_q <= bus.wdata[15:0];
                R_SLP_CNT:   sleep_cycle_count_q <= bus.wdata[15:0];
                R_SLP_KIND:  sleep_kind_q <= bus.wdata[2:0];
                R_SLP_OPT:   sleep_opt_q <= bus.wdata[7:0];
                R_WAKE_HOLD: wake_hold_time_q <= bus.wdata[15:0];
                R_PWM0:      pwm_duty_zero_q <= bus.wdata[9:0]; // RQ10
                R_PWM1:      pwm_duty_one_q <= bus.wdata[9:0];
                R_DEST_HI:   dest_addr_high_q <= bus.wdata;
                R_DEST_LO:   dest_addr_low_q <= bus.wdata;
                R_ADC_REF:   adc_reference_select <= bus.wdata[1:0];
                default: ;
            endcase
        end
    end

    // Per-line decode; upper pins five to nine enter this mask like any line
    logic [14:0] dig_en, out_en, out_hi;
    logic [3:0]  adc_en;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
            assign dig_en[gi] = is_digital(line_fn_q[gi]); // RQ6 RQ8
            assign out_en[gi] = line_fn_q[gi] == FN_DLOW || line_fn_q[gi] == FN_DHIGH;
            assign out_hi[gi] = line_fn_q[gi] == FN_DHIGH;
        end
        for (gi = 0; gi < NUM_ADC; gi++) begin : g_adc
            assign adc_en[gi] = line_fn_q[gi] == FN_ADC; // RQ9
        end
    endgenerate

    logic [1:0] pwm_raw;
    ils_pwm #(.WIDTH(ADC_BITS)) u_pwm0 (
        .clk(clk), .rst(rst), .duty(pwm_duty_zero_q), .pwm_out(pwm_raw[0]));
    ils_pwm #(.WIDTH(ADC_BITS)) u_pwm1 (
        .clk(clk), .rst(rst), .duty(pwm_duty_one_q), .pwm_out(pwm_raw[1]));

    // Pin drive registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe  <= '0;
            pull_en <= '0;
            pull_up <= '1;
            pwm_out <= '0;
        end else begin
            pin_out <= out_hi; // RQ23
            pin_oe  <= out_en;
            pull_en <= pull_enable_mask_q & ~out_en; // RQ7
            pull_up <= pull_direction_mask_q;
            pwm_out <= pwm_raw; // RQ10
        end
    end

    // Sleep sequencer
    typedef enum logic [3:0] {
        ST_AWAKE = 4'h1,
        ST_HOLD  = 4'h2,
        ST_SLEEP = 4'h4,
        ST_WAKE  = 4'h8
    } ils_state_t;
    ils_state_t state_q;

    logic cyc_kind, ext_on, hold_on;
    assign cyc_kind = sleep_kind_q == KIND_CYC || sleep_kind_q == KIND_CYC_PIN; // RQ3
    assign ext_on   = sleep_opt_q == OPT_EXT || sleep_opt_q == OPT_EXT_HOLD; // RQ2
    assign hold_on  = sleep_opt_q == OPT_EXT_HOLD || !ext_on;

    logic [31:0] sleep_units;
    logic        slp_run, slp_done, hold_run, hold_done;
    logic        enter_sleep, pin_wake;
    assign sleep_units = ext_on ? sleep_period_q * sleep_cycle_count_q // RQ1
                                : {16'h0, sleep_period_q};
    assign pin_wake    = sleep_kind_q == KIND_CYC_PIN && sleep_req_pin; // RQ3

    ils_timer #(.PRESCALE(MS_CYC * SLEEP_UNIT_MS)) u_slp (
        .clk(clk), .rst(rst), .start(enter_sleep),
        .stop(pin_wake || !cyc_kind),
        .units(sleep_units), .running(slp_run), .done(slp_done)); // RQ1

    logic wake_evt;
    assign wake_evt = state_q == ST_SLEEP && (slp_done || pin_wake);
    assign enter_sleep = cyc_kind && state_q != ST_SLEEP &&
                         (sleep_now_cmd || (state_q == ST_HOLD &&
                          (hold_done || !hold_on))); // RQ5 RQ2

    ils_timer #(.PRESCALE(MS_CYC)) u_hold (
        .clk(clk), .rst(rst), .start(state_q == ST_WAKE),
        .stop(sleep_now_cmd || enter_sleep || !cyc_kind),
        .units({16'h0, wake_hold_time_q}),
        .running(hold_run), .done(hold_done)); // RQ4 RQ21

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_AWAKE;
        end else begin
            case (state_q)
                ST_AWAKE: if (enter_sleep) state_q <= ST_SLEEP;
                          else if (cyc_kind) state_q <= ST_WAKE;
                ST_WAKE:  state_q <= enter_sleep ? ST_SLEEP : ST_HOLD;
                ST_HOLD:  if (enter_sleep) state_q <= ST_SLEEP; // RQ4 RQ5
                          else if (!cyc_kind) state_q <= ST_AWAKE;
                          else if (!hold_on) state_q <= ST_SLEEP;
                ST_SLEEP: if (wake_evt) state_q <= ST_WAKE;
                          else if (!cyc_kind) state_q <= ST_AWAKE;
                default:  state_q <= ST_AWAKE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) asleep <= 1'b0;
        else     asleep <= state_q == ST_SLEEP;
    end

    // Periodic timer restarts on each expiry
    logic per_done, per_start, cyc_wake_q;
    assign per_start = periodic_sample_interval_q != 0 && state_q != ST_SLEEP;
    ils_timer #(.PRESCALE(MS_CYC)) u_per (
        .clk(clk), .rst(rst), .start(per_start),
        .stop(!per_start), .units({16'h0, periodic_sample_interval_q}),
        .running(), .done(per_done)); // RQ15 RQ21

    // Cyclic wake samples at once; pin sleep wake is not this path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cyc_wake_q <= 1'b0;
        else     cyc_wake_q <= wake_evt && slp_done; // RQ15
    end

    // Change detect on digital inputs
    logic [14:0] pin_prev_q;
    logic [14:0] din_mask;
    logic        change_evt;
    assign din_mask = change_detect_mask_q & dig_en & ~out_en;
    assign change_evt = |((pin_in ^ pin_prev_q) & din_mask); // RQ16
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pin_prev_q <= '0;
        else     pin_prev_q <= pin_in;
    end

    // Sample capture; all three sources merge
    logic [2:0]  src;
    logic        any_cfg;
    logic [14:0] levels;
    assign src = ({3{per_done || cyc_wake_q}} & SRC_TIMER) |
                 ({3{change_evt}} & SRC_CHANGE) |
                 ({3{force_sample_cmd}} & SRC_FORCE); // RQ18 RQ17
    assign any_cfg = |dig_en || |adc_en; // RQ13
    assign levels  = (pin_in & ~out_en) | (out_hi & out_en); // RQ22 RQ23

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sample       <= '0;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= (src != 0) && any_cfg; // RQ13
            if (src != 0 && any_cfg) begin
                sample.source    <= src;
                sample.dig_mask  <= dig_en;
                sample.dig_data  <= levels & dig_en; // RQ22
                sample.adc_mask  <= adc_en;
                for (int i = 0; i < NUM_ADC; i++) begin
                    sample.adc_data[i] <= adc_en[i] ?
                        {6'h00, adc_in[i]} & ADC_MAX : 16'h0000; // RQ11
                end
                sample.dest_high <= dest_addr_high_q; // RQ14
                sample.dest_low  <= dest_addr_low_q;
            end
        end
    end

    // Readback
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else if (bus.re) begin
            rdata <= '0;
            if (bus.addr < 6'(NUM_LINES))
                rdata <= {29'h0, line_fn_q[bus.addr[3:0]]};
            case (bus.addr)
                R_PULL_EN:   rdata <= {17'h0, pull_enable_mask_q};
                R_PULL_DIR:  rdata <= {17'h0, pull_direction_mask_q};
                R_CHG_MASK:  rdata <= {17'h0, change_detect_mask_q};
                R_INTERVAL:  rdata <= {16'h0, periodic_sample_interval_q};
                R_SLP_PER:   rdata <= {16'h0, sleep_period_q};
                R_SLP_CNT:   rdata <= {16'h0, sleep_cycle_count_q};
                R_SLP_KIND:  rdata <= {29'h0, sleep_kind_q};
                R_SLP_OPT:   rdata <= {24'h0, sleep_opt_q};
                R_WAKE_HOLD: rdata <= {16'h0, wake_hold_time_q};
                R_PWM0:      rdata <= {22'h0, pwm_duty_zero_q};
                R_PWM1:      rdata <= {22'h0, pwm_duty_one_q};
                R_DEST_HI:   rdata <= dest_addr_high_q;
                R_DEST_LO:   rdata <= dest_addr_low_q;
                R_ADC_REF:   rdata <= {30'h0, adc_reference_select};
                R_STATUS:    rdata <= {28'h0, state_q};
                R_SAMP_DIG:  rdata <= {17'h0, sample.dig_data};
                R_SAMP_MASK: rdata <= {17'h0, sample.dig_mask};
                R_SAMP_AMSK: rdata <= {28'h0, sample.adc_mask};
                default: begin
                    if (bus.addr >= R_SAMP_ADC && bus.addr < R_SAMP_ADC + 6'h4)
                        rdata <= {16'h0, sample.adc_data[bus.addr[1:0]]};
                end
            endcase
        end else begin
            rdata <= '0;
        end
    end

    // Checks
    a_no_cfg_sample: assert property (@(posedge clk) disable iff (rst) // RQ13
        !any_cfg |=> !sample_valid) else $error("sample without lines");
    a_force_sample: assert property (@(posedge clk) disable iff (rst) // RQ17
        force_sample_cmd && any_cfg |=> sample_valid && sample.source[2])
        else $error("force sample lost");
    a_sleep_now: assert property (@(posedge clk) disable iff (rst) // RQ5
        sleep_now_cmd && cyc_kind && state_q != ST_SLEEP |=> ##1 asleep)
        else $error("sleep-now ignored");
    a_out_drive: assert property (@(posedge clk) disable iff (rst) // RQ23
        1'b1 |=> pin_out == $past(out_hi) && pin_oe == $past(out_en))
        else $error("pin drive stale");
    a_adc_range: assert property (@(posedge clk) disable iff (rst) // RQ11
        sample_valid |-> sample.adc_data[0] <= ADC_MAX)
        else $error("adc out of range");
    a_adc_lines: assert property (@(posedge clk) disable iff (rst) // RQ9
        line_fn_q[4] != FN_ADC) else $error("adc on upper line");
    a_change_samp: assert property (@(posedge clk) disable iff (rst) // RQ16
        change_evt && any_cfg |=> sample_valid && sample.source[1])
        else $error("change sample lost");
    a_dest_copy: assert property (@(posedge clk) disable iff (rst) // RQ14
        sample_valid |-> sample.dest_low == $past(dest_addr_low_q))
        else $error("dest wrong");
endmodule

// ### tb/ils_rx_model.sv
`timescale 1ns/100ps
module ils_rx_model
    import ils_pkg::*;
(
    // Clock
    input  wire logic                 clk,
    // Pushed samples
    input  wire ils_pkg::ils_sample_t sample,
    input  wire logic                 sample_valid,
    // Receiver view
    output int                        n_rx,
    output int                        adc0_mv
);
    // Framed mode, so every pushed sample is taken
    always @(posedge clk) begin
        if (sample_valid === 1'b1) begin
            n_rx <= n_rx + 1;
            // Default 1.25 V reference over 1023 steps
            adc0_mv <= int'(sample.adc_data[0]) * 1250 / 1023;
        end
    end
endmodule

// ### tb/ils_core_tb.sv
`timescale 1ns/100ps
module ils_core_tb;
    import ils_pkg::*;
    localparam int MSC = 4;
    localparam logic [63:0] DEST = 64'h0000_00A1_0000_00B2;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    ils_bus_t      bus = '0;
    logic [31:0]   rdata;
    logic [14:0]   pin_in;
    logic [14:0]   ext_lvl = '0;
    logic [3:0][9:0] adc_in = '0;
    logic          slp_pin = 1'b0;
    logic [14:0]   pin_out;
    logic [14:0]   pin_oe;
    logic [14:0]   pull_en;
    logic [14:0]   pull_up;
    logic [1:0]    pwm_out;
    logic [1:0]    aref;
    ils_sample_t   sample;
    logic          sample_valid;
    logic          asleep;
    logic          prev = 1'b0;
    logic [31:0]   rng = 32'h5357D8B5;
    int            n_mismatch = 0;
    int            cmp_count = 0;
    int            fn[15];
    int            len[2];
    int            run = 0;
    int            n_rx;
    int            mv;

    always #4 clk = ~clk;
    // Output lines drive the wire, the rest follow the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);

    ils_core #(.MS_CYC(MSC)) i_ils_core (.clk(clk), .rst(rst), .bus(bus),
        .rdata(rdata), .pin_in(pin_in), .adc_in(adc_in),
        .sleep_req_pin(slp_pin), .pin_out(pin_out), .pin_oe(pin_oe),
        .pull_en(pull_en), .pull_up(pull_up), .pwm_out(pwm_out),
        .adc_reference_select(aref), .sample(sample),
        .sample_valid(sample_valid), .asleep(asleep));
    ils_rx_model i_ils_rx_model (.clk(clk), .sample(sample),
        .sample_valid(sample_valid), .n_rx(n_rx), .adc0_mv(mv));

    // Length of the last awake and asleep stretch, in cycles
    always @(negedge clk) begin
        if (asleep === prev) begin
            run++;
        end else begin
            len[prev] = run;
            run = 1;
            prev = asleep;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] s, input logic [63:0] e,
                       input string what);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %0t %s seen %0h exp %0h", $time, what, s, e);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.we <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        bus.re <= 1'b0;
        #1 chk(rdata, e, "read");
    endtask

    task automatic setfn(input int ln, input int v);
        wr(R_FN_BASE + 6'(ln), 32'(v));
        if (ln < 4 || v != 2) fn[ln] = v;
    endtask

    // Wait for a sample, then compare it with the line model
    task automatic samp(input logic [2:0] src);
        logic [14:0] m;
        logic [14:0] dv;
        logic [3:0]  am;
        int          i;
        i = 0;
        while (sample_valid !== 1'b1 && i < 20) begin
            @(negedge clk);
            i++;
        end
        m = '0;
        dv = '0;
        am = '0;
        for (i = 0; i < 15; i++) begin
            m[i] = fn[i] >= 3 && fn[i] <= 5;
            dv[i] = fn[i] == 5 || (fn[i] == 3 && ext_lvl[i]);
            am[i % 4] = am[i % 4] | (i < 4 && fn[i] == 2);
        end
        chk(sample_valid, 1, "no sample");
        chk(sample.source, src, "source");
        chk(sample.dig_mask, m, "dig mask");
        chk(sample.dig_data & m, dv, "dig data");
        chk(sample.adc_mask, am, "adc mask");
        chk(sample.adc_data[0], {6'h0, adc_in[0]}, "adc0");
        chk({sample.dest_high, sample.dest_low}, DEST, "dest");
        @(negedge clk);
    endtask

    initial begin
        #200000;
        n_mismatch++;
        complete_run;
    end

    initial begin
        int i;
        int n;
        time t0;
        for (i = 0; i < 15; i++) fn[i] = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(R_WAKE_HOLD, 32'(WAKE_HOLD_RST));
        chk(pull_up, 15'h7FFF, "pull up");
        wr(R_CMD, 32'h1);
        repeat (3) @(negedge clk);
        chk(n_rx, 0, "empty sample");
        wr(R_DEST_HI, DEST[63:32]);
        wr(R_DEST_LO, DEST[31:0]);
        @(posedge clk);
        rng = xs(rng);
        adc_in <= {rng[31:22], rng[21:12], rng[11:2], rng[9:0]};
        ext_lvl <= rng[30:16];
        setfn(0, 2);
        setfn(1, 3);
        setfn(2, 4);
        setfn(3, 5);
        repeat (2) @(negedge clk);
        chk({pin_oe[3:2], pin_out[3:2]}, 4'hE, "drive");
        setfn(4, 2);
        setfn(14, 3);
        rd(R_FN_BASE + 6'h04, 32'h0);
        rd(6'h3F, 32'h0);
        wr(R_CMD, 32'h1);
        samp(SRC_FORCE);
        chk(mv, adc_in[0] * 1250 / 1023, "volts");
        setfn(2, 5);
        wr(R_CMD, 32'h1);
        samp(SRC_FORCE);
        // Only the masked input may trigger
        wr(R_CHG_MASK, 32'h2);
        n = n_rx;
        @(posedge clk);
        ext_lvl[14] <= ~ext_lvl[14];
        repeat (6) @(negedge clk);
        chk(n_rx, n, "unmasked change");
        @(posedge clk);
        ext_lvl[1] <= ~ext_lvl[1];
        samp(SRC_CHANGE);
        wr(R_CHG_MASK, 32'h0);
        wr(R_INTERVAL, 32'h3);
        samp(SRC_TIMER);
        t0 = $time;
        samp(SRC_TIMER);
        chk(($time - t0) / 8, 3 * MSC, "interval");
        wr(R_INTERVAL, 32'h0);
        wr(R_PWM0, 32'd256);
        wr(R_PWM1, 32'h3FF);
        // Duty passes two registers before the pin
        repeat (2) @(negedge clk);
        n = 0;
        repeat (1024) @(negedge clk) n += pwm_out[0];
        chk(n >= 255 && n <= 257, 1, "pwm duty");
        chk(pwm_out[1], 1, "pwm full");
        rng = xs(rng);
        wr(R_PULL_EN, rng[14:0]);
        wr(R_PULL_DIR, rng[30:16]);
        wr(R_ADC_REF, 32'h2);
        @(negedge clk);
        // Lines two and three drive, so their pulls stay off
        chk({aref, pull_en, pull_up},
            {2'h2, rng[14:0] & 15'h7FF3, rng[30:16]}, "pull");
        wr(R_SLP_PER, 32'h1);
        wr(R_SLP_CNT, 32'h3);
        wr(R_WAKE_HOLD, 32'h2);
        wr(R_SLP_OPT, 32'(OPT_EXT_HOLD));
        wr(R_SLP_KIND, 32'(KIND_CYC));
        wr(R_CMD, 32'h2);
        repeat (2) @(negedge clk);
        chk(asleep, 1, "sleep now");
        for (i = 0; i < 400 && asleep === 1'b1; i++) @(negedge clk);
        samp(SRC_TIMER);
        chk(len[1] >= 118 && len[1] <= 122, 1, "ext sleep");
        for (i = 0; i < 40 && asleep === 1'b0; i++) @(negedge clk);
        @(negedge clk);
        chk(len[0] >= 6 && len[0] <= 10, 1, "wake hold");
        wr(R_SLP_KIND, 32'(KIND_CYC_PIN));
        n = n_rx;
        @(posedge clk);
        slp_pin <= 1'b1;
        repeat (4) @(negedge clk);
        chk({asleep, n_rx}, {1'b0, n}, "pin wake");
        // Plain extended sleep skips the wake hold
        @(posedge clk);
        slp_pin <= 1'b0;
        wr(R_SLP_OPT, 32'(OPT_EXT));
        for (i = 0; i < 40 && asleep === 1'b0; i++) @(negedge clk);
        for (i = 0; i < 400 && asleep === 1'b1; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        chk(len[0] < 4 && asleep, 1, "no hold");
        complete_run;
    end
endmodule
